// >>> core/ata_security_verify_cmd.sv
// Task-file command handler: 48-bit verify, no-op, and the security command group.
// Assumes a classic Wishbone master, a sector checker that answers each request with
// a done pulse, and a power-on reset that is asserted together with reset_n at power-up.
//
// Overview of operation
// - Verify never raises data request, moves nothing.
// - Verify sets busy, clears and interrupts after.
// - Good verify leaves last checked address.
// - Failed verify keeps failing address, count from failing sector on.
// - High-order select picks previous or current byte.
// - Upper nibble one opcodes complete as no-op.
// - Password commands take exactly one data sector.
// - Word zero control, sixteen password words follow.
// - Disable password with match turns lock off.
// - Disable password keeps stored master password.
// - Erase aborts without immediately preceding prepare.
// - Erase with wrong password aborts.
// - Frozen rejects set, unlock, disable, erase.
// - Only hardware reset leaves frozen state.
// - Freeze while frozen still succeeds.
// - Freeze completion zeroes the count register.
// - Without security, freeze runs wear-level.
// - Set password: bit eight level, bit zero target.
// - User password arms lock from next reset.
// - High level accepts user or master password.
// - Maximum level never honours master password.
// - Master password set leaves lock, level alone.
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
module ata_security_verify_cmd #(
  parameter bit SECURITY_EN = 1'b1
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic por_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host interrupt line
  output logic host_intrq,
  // Sector checker
  output ata_sec_pkg::check_req_t check,
  input wire logic check_done,
  input wire logic check_bad,
  // Media actions
  output logic erase_start,
  output logic wear_level_start
);

  // ****************************************************************
  // State and storage
  // ****************************************************************
  ata_sec_pkg::cmd_state_t state;
  logic [7:0] cur_op;
  logic [7:0] feature;
  logic [15:0] count;
  logic [15:0] addr_lower;
  logic [15:0] addr_middle;
  logic [15:0] addr_upper;
  logic [7:0] drive;
  logic [7:0] dev_ctrl;
  logic err_abort;
  logic intrq_pend;
  logic [47:0] work_lba;
  logic [16:0] remaining;
  logic [7:0] word_idx;
  logic [15:0] ctrl_word;
  logic [255:0] pw_buf;
  logic [255:0] user_pw;
  logic [255:0] master_pw;
  logic armed;
  logic level_max;
  logic locked;
  logic frozen;
  logic prepared;
  logic load_pending;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = bus_req & wb_we_i & wb_sel_i[0];
  wire rd = bus_req & ~wb_we_i;
  wire idle = (state == ata_sec_pkg::ST_IDLE);
  wire busy = (state == ata_sec_pkg::ST_CHECK) | (state == ata_sec_pkg::ST_EXECUTE);
  wire data_request_bit = (state == ata_sec_pkg::ST_SECTOR_IN);
  wire high_order_select = dev_ctrl[ata_sec_pkg::CTRL_HOB_BIT];
  wire hit_data = (wb_adr_i == ata_sec_pkg::OFF_DATA);
  wire hit_cmd = (wb_adr_i == ata_sec_pkg::OFF_CMD_STATUS);
  wire hit_ctrl = (wb_adr_i == ata_sec_pkg::OFF_DEV_CTRL);
  wire tf_wr = wr & idle;
  wire ctrl_wr = wr & hit_ctrl;
  wire soft_reset = ctrl_wr & wb_dat_i[ata_sec_pkg::CTRL_SRST_BIT];
  wire data_wr = bus_req & wb_we_i & (&wb_sel_i[1:0]) & hit_data & data_request_bit;
  wire status_rd = rd & hit_cmd;

  // ****************************************************************
  // Command classification
  // ****************************************************************
  wire [7:0] op = wb_dat_i[7:0];
  wire cmd_write = tf_wr & hit_cmd;
  wire is_verify = (op == ata_sec_pkg::OP_VERIFY_EXT);
  wire is_nop = (op[7:4] == ata_sec_pkg::OP_NOP_NIBBLE);
  wire is_setpw = SECURITY_EN & (op == ata_sec_pkg::OP_SET_PW);
  wire is_unlock = SECURITY_EN & (op == ata_sec_pkg::OP_UNLOCK);
  wire is_prep = SECURITY_EN & (op == ata_sec_pkg::OP_ERASE_PREP);
  wire is_erase = SECURITY_EN & (op == ata_sec_pkg::OP_ERASE_UNIT);
  wire is_disable = SECURITY_EN & (op == ata_sec_pkg::OP_DISABLE_PW);
  wire is_freeze = (op == ata_sec_pkg::OP_FREEZE);
  wire needs_data = is_setpw | is_disable | is_erase;
  wire known = is_verify | is_nop | is_prep | is_freeze | needs_data;
  // Unlock is not carried by this block, so it always aborts; while frozen it would anyway.
  wire frozen_block = frozen & (needs_data | is_unlock);
  wire erase_noprep = is_erase & ~prepared;
  wire cmd_abort = cmd_write & (~known | frozen_block | erase_noprep);
  wire cmd_ok = cmd_write & ~cmd_abort;
  wire start_verify = cmd_ok & is_verify;
  wire start_data = cmd_ok & needs_data;
  wire freeze_done = cmd_ok & is_freeze;
  wire instant_done = cmd_write & ~start_verify & ~start_data;

  // ****************************************************************
  // Verify engine decode
  // ****************************************************************
  wire checking = (state == ata_sec_pkg::ST_CHECK);
  wire chk_fail = checking & check_done & check_bad;
  wire chk_last = checking & check_done & ~check_bad & (remaining == 17'h00001);
  wire chk_step = checking & check_done & ~check_bad & (remaining != 17'h00001);
  wire verify_end = chk_fail | chk_last;
  wire [47:0] lba48 = {addr_upper[15:8], addr_middle[15:8], addr_lower[15:8],
                       addr_upper[7:0], addr_middle[7:0], addr_lower[7:0]};

  // ****************************************************************
  // Password execution decode
  // ****************************************************************
  wire exec = (state == ata_sec_pkg::ST_EXECUTE);
  wire id_master = ctrl_word[ata_sec_pkg::PW_ID_BIT];
  wire level_bit = ctrl_word[ata_sec_pkg::PW_LEVEL_BIT];
  wire master_ok = (pw_buf == master_pw) & ~level_max;
  wire pw_match = id_master ? master_ok : (pw_buf == user_pw);
  wire exec_setpw = exec & (cur_op == ata_sec_pkg::OP_SET_PW);
  wire exec_erase = exec & (cur_op == ata_sec_pkg::OP_ERASE_UNIT);
  wire exec_fail = exec & ~exec_setpw & ~pw_match;
  wire exec_unlock = exec & ~exec_setpw & pw_match;
  wire done = instant_done | verify_end | exec;
  wire done_err = cmd_abort | chk_fail | exec_fail;
  wire last_word = data_wr & (word_idx == ata_sec_pkg::SECTOR_LAST_WORD);

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ata_sec_pkg::ST_IDLE;
      cur_op <= ata_sec_pkg::RST_BYTE;
    end else if (soft_reset) begin
      state <= ata_sec_pkg::ST_IDLE;
    end else begin
      unique case (state)
        ata_sec_pkg::ST_IDLE: begin
          if (start_verify) begin
            state <= ata_sec_pkg::ST_CHECK;
          end else if (start_data) begin
            state <= ata_sec_pkg::ST_SECTOR_IN;
          end
        end
        ata_sec_pkg::ST_CHECK: begin
          if (verify_end) begin
            state <= ata_sec_pkg::ST_IDLE;
          end
        end
        ata_sec_pkg::ST_SECTOR_IN: begin
          if (last_word) begin
            state <= ata_sec_pkg::ST_EXECUTE;
          end
        end
        ata_sec_pkg::ST_EXECUTE: begin
          state <= ata_sec_pkg::ST_IDLE;
        end
      endcase
      if (cmd_write) begin
        cur_op <= op;
      end
    end
  end

  // ****************************************************************
  // Error and interrupt flags
  // ****************************************************************
  // A completion in the same cycle as a status read keeps the interrupt pending.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_abort <= 1'b0;
      intrq_pend <= 1'b0;
    end else begin
      if (done) begin
        err_abort <= done_err;
      end else if (soft_reset) begin
        err_abort <= 1'b0;
      end
      // A new command write also retires an interrupt that the host never acknowledged.
      intrq_pend <= done | (intrq_pend & ~status_rd & ~soft_reset & ~cmd_write);
    end
  end

  assign host_intrq = intrq_pend & ~dev_ctrl[ata_sec_pkg::CTRL_NIEN_BIT];

  // ****************************************************************
  // Task-file registers
  // ****************************************************************
  // Each count or address byte write pushes the current byte into the previous half.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      feature <= ata_sec_pkg::RST_BYTE;
      count <= ata_sec_pkg::RST_TASKFILE;
      addr_lower <= ata_sec_pkg::RST_TASKFILE;
      addr_middle <= ata_sec_pkg::RST_TASKFILE;
      addr_upper <= ata_sec_pkg::RST_TASKFILE;
      drive <= ata_sec_pkg::RST_BYTE;
      dev_ctrl <= ata_sec_pkg::RST_BYTE;
    end else begin
      if (tf_wr & (wb_adr_i == ata_sec_pkg::OFF_FEATURE)) begin
        feature <= op;
      end
      if (tf_wr & (wb_adr_i == ata_sec_pkg::OFF_DRIVE)) begin
        drive <= op;
      end
      if (ctrl_wr) begin
        dev_ctrl <= op;
      end
      if (tf_wr & (wb_adr_i == ata_sec_pkg::OFF_COUNT)) begin
        count <= {count[7:0], op};
      end else if (freeze_done) begin
        count <= ata_sec_pkg::RST_TASKFILE;
      end else if (chk_fail) begin
        count <= remaining[15:0];
      end
      if (tf_wr & (wb_adr_i == ata_sec_pkg::OFF_ADDR_LOWER)) begin
        addr_lower <= {addr_lower[7:0], op};
      end
      if (tf_wr & (wb_adr_i == ata_sec_pkg::OFF_ADDR_MIDDLE)) begin
        addr_middle <= {addr_middle[7:0], op};
      end
      if (tf_wr & (wb_adr_i == ata_sec_pkg::OFF_ADDR_UPPER)) begin
        addr_upper <= {addr_upper[7:0], op};
      end
      if (verify_end) begin
        addr_upper <= {work_lba[47:40], work_lba[23:16]};
        addr_middle <= {work_lba[39:32], work_lba[15:8]};
        addr_lower <= {work_lba[31:24], work_lba[7:0]};
      end
    end
  end

  // ****************************************************************
  // Verify engine
  // ****************************************************************
  // A zero count asks for the full 65536 sectors.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      work_lba <= 48'h000000000000;
      remaining <= 17'h00000;
    end else if (start_verify) begin
      work_lba <= lba48;
      remaining <= (count == 16'h0000) ? ata_sec_pkg::FULL_COUNT : {1'b0, count};
    end else if (chk_step) begin
      work_lba <= work_lba + 48'h000000000001;
      remaining <= remaining - 17'h00001;
    end
  end

  // The checker only reads media; nothing reaches the data port.
  assign check = '{req: checking, lba: work_lba};

  // ****************************************************************
  // Password sector intake
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word_idx <= ata_sec_pkg::RST_BYTE;
      ctrl_word <= ata_sec_pkg::RST_TASKFILE;
      pw_buf <= ata_sec_pkg::RST_PASSWORD;
    end else if (start_data) begin
      word_idx <= ata_sec_pkg::RST_BYTE;
    end else if (data_wr) begin
      word_idx <= word_idx + 8'h01;
      if (word_idx == 8'h00) begin
        ctrl_word <= wb_dat_i[15:0];
      end else if (word_idx <= ata_sec_pkg::PW_LAST_WORD) begin
        pw_buf <= {wb_dat_i[15:0], pw_buf[255:16]};
      end
    end
  end

  // ****************************************************************
  // Stored secrets, kept across hardware reset
  // ****************************************************************
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      user_pw <= ata_sec_pkg::RST_PASSWORD;
      master_pw <= ata_sec_pkg::RST_PASSWORD;
      armed <= 1'b0;
      level_max <= 1'b0;
    end else if (exec_setpw & id_master) begin
      master_pw <= pw_buf;
    end else if (exec_setpw) begin
      user_pw <= pw_buf;
      armed <= 1'b1;
      level_max <= level_bit;
    end else if (exec_unlock) begin
      armed <= 1'b0;
      if (exec_erase) begin
        user_pw <= ata_sec_pkg::RST_PASSWORD;
      end
    end
  end

  // ****************************************************************
  // Lock, freeze and prepare states
  // ****************************************************************
  // Lock is sampled from the armed flag at the first edge after hardware reset, so a
  // newly set user password only locks the unit from the next reset onward.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      locked <= 1'b0;
      load_pending <= 1'b1;
      frozen <= 1'b0;
      prepared <= 1'b0;
    end else begin
      load_pending <= 1'b0;
      if (load_pending) begin
        locked <= armed;
      end else if (exec_unlock) begin
        locked <= 1'b0;
      end
      if (freeze_done & SECURITY_EN) begin
        frozen <= 1'b1;
      end
      if (cmd_write) begin
        prepared <= cmd_ok & is_prep;
      end
    end
  end

  // ****************************************************************
  // Media action strobes
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      erase_start <= 1'b0;
      wear_level_start <= 1'b0;
    end else begin
      erase_start <= exec_erase & pw_match;
      wear_level_start <= freeze_done & ~SECURITY_EN;
    end
  end

  // ****************************************************************
  // Read mux and bus answer
  // ****************************************************************
  ata_sec_pkg::sec_state_t sec_view;
  assign sec_view = '{prepared: prepared, level_max: level_max, frozen: frozen,
                      armed: armed, locked: locked};
  wire [7:0] status_byte = {busy, ~busy, 2'b00, data_request_bit, 2'b00, err_abort};
  wire [7:0] error_byte = {5'b00000, err_abort, 2'b00};
  wire [7:0] rd_count = high_order_select ? count[15:8] : count[7:0];
  wire [7:0] rd_lower = high_order_select ? addr_lower[15:8] : addr_lower[7:0];
  wire [7:0] rd_middle = high_order_select ? addr_middle[15:8] : addr_middle[7:0];
  wire [7:0] rd_upper = high_order_select ? addr_upper[15:8] : addr_upper[7:0];
  wire [7:0] rd_byte =
    (wb_adr_i == ata_sec_pkg::OFF_FEATURE) ? feature :
    (wb_adr_i == ata_sec_pkg::OFF_COUNT) ? rd_count :
    (wb_adr_i == ata_sec_pkg::OFF_ADDR_LOWER) ? rd_lower :
    (wb_adr_i == ata_sec_pkg::OFF_ADDR_MIDDLE) ? rd_middle :
    (wb_adr_i == ata_sec_pkg::OFF_ADDR_UPPER) ? rd_upper :
    (wb_adr_i == ata_sec_pkg::OFF_DRIVE) ? drive :
    (wb_adr_i == ata_sec_pkg::OFF_CMD_STATUS) ? status_byte :
    (wb_adr_i == ata_sec_pkg::OFF_DEV_CTRL) ? dev_ctrl :
    (wb_adr_i == ata_sec_pkg::OFF_ERROR) ? error_byte :
    (wb_adr_i == ata_sec_pkg::OFF_SEC_STATUS) ? {3'b000, sec_view} : 8'h00;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n || !por_n);

  sequence s_verify_ok;
    checking && check_done && !check_bad && remaining == 17'h00001;
  endsequence

  sequence s_verify_bad;
    checking && check_done && check_bad;
  endsequence

  property p_verify_no_drq;
    start_verify |=> (!data_request_bit && busy) until (!busy);
  endproperty
  a_verify_no_drq: assert property (p_verify_no_drq) else $error("drq during verify");

  property p_verify_busy;
    start_verify |=> busy && !intrq_pend;
  endproperty
  a_verify_busy: assert property (p_verify_busy) else $error("verify not busy");

  property p_verify_end_irq;
    s_verify_ok |=> !busy && intrq_pend && !err_abort;
  endproperty
  a_verify_end_irq: assert property (p_verify_end_irq) else $error("verify end wrong");

  property p_verify_last_lba;
    s_verify_ok |=> lba48 == $past(work_lba);
  endproperty
  a_verify_last_lba: assert property (p_verify_last_lba) else $error("last lba lost");

  property p_verify_fail;
    s_verify_bad |=> err_abort && lba48 == $past(work_lba) && count == $past(remaining[15:0]);
  endproperty
  a_verify_fail: assert property (p_verify_fail) else $error("fail report wrong");

  property p_nop;
    cmd_write && is_nop |=> idle && !err_abort && $stable({frozen, armed, locked, level_max})
      && $stable(count);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op misbehaved");

  property p_erase_prep;
    cmd_write && is_erase && !prepared |=> idle && err_abort;
  endproperty
  a_erase_prep: assert property (p_erase_prep) else $error("erase ran unprepared");

  property p_frozen_reject;
    cmd_write && frozen && needs_data |=> idle && err_abort && !data_request_bit;
  endproperty
  a_frozen_reject: assert property (p_frozen_reject) else $error("frozen accepted");

  property p_frozen_sticky;
    frozen |=> frozen;
  endproperty
  a_frozen_sticky: assert property (p_frozen_sticky) else $error("frozen cleared");

  property p_freeze;
    freeze_done && SECURITY_EN |=> frozen && count == 16'h0000 && !err_abort;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze result wrong");

  property p_master_keeps_lock;
    exec_setpw && id_master |=> $stable(armed) && $stable(level_max) && $stable(user_pw);
  endproperty
  a_master_keeps_lock: assert property (p_master_keeps_lock) else $error("lock changed");

endmodule

// >>> core/ata_sec_pkg.sv
// Shared constants and types for the task-file security and verify command handler.
// Assumes a 32-bit classic Wishbone master with byte addresses and 8-bit task-file data.
package ata_sec_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_FEATURE = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_ADDR_LOWER = 8'h0C;
  localparam logic [7:0] OFF_ADDR_MIDDLE = 8'h10;
  localparam logic [7:0] OFF_ADDR_UPPER = 8'h14;
  localparam logic [7:0] OFF_DRIVE = 8'h18;
  localparam logic [7:0] OFF_CMD_STATUS = 8'h1C;
  localparam logic [7:0] OFF_DEV_CTRL = 8'h20;
  localparam logic [7:0] OFF_ERROR = 8'h24;
  localparam logic [7:0] OFF_SEC_STATUS = 8'h28;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_VERIFY_EXT = 8'h42;
  localparam logic [7:0] OP_SET_PW = 8'hF1;
  localparam logic [7:0] OP_UNLOCK = 8'hF2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
  localparam logic [7:0] OP_FREEZE = 8'hF5;
  localparam logic [7:0] OP_DISABLE_PW = 8'hF6;
  localparam logic [3:0] OP_NOP_NIBBLE = 4'h1;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_DRQ_BIT = 3;
  localparam int STAT_ERR_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int CTRL_HOB_BIT = 7;
  localparam int CTRL_SRST_BIT = 2;
  localparam int CTRL_NIEN_BIT = 1;
  localparam int PW_ID_BIT = 0;
  localparam int PW_LEVEL_BIT = 8;
  localparam logic [7:0] PW_LAST_WORD = 8'h10;
  localparam logic [7:0] SECTOR_LAST_WORD = 8'hFF;
  localparam logic [15:0] RST_TASKFILE = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [255:0] RST_PASSWORD = 256'h0;
  localparam logic [16:0] FULL_COUNT = 17'h10000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_SECTOR_IN = 2'b10,
    ST_EXECUTE = 2'b11
  } cmd_state_t;

  typedef struct packed {
    logic prepared;
    logic level_max;
    logic frozen;
    logic armed;
    logic locked;
  } sec_state_t;

  typedef struct packed {
    logic req;
    logic [47:0] lba;
  } check_req_t;

endpackage

// >>> bench/sector_checker_model.sv
// Stand-in for the sector checker behind the verify engine.
// Assumes a request stands until answered; answers alternate between prompt and slow.
`timescale 1ns/1ns
module sector_checker_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Request and the sector that should fail
  input wire ata_sec_pkg::check_req_t check,
  input wire logic [47:0] bad_lba,
  // Answer
  output logic check_done,
  output logic check_bad
);
  logic [1:0] wait_n;
  logic slow;
  // The bad flag toggles outside answers so a stale value never looks valid.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {wait_n, slow, check_done, check_bad} <= 5'h00;
    end else if (check.req && !check_done && wait_n == (slow ? 2'h3 : 2'h1)) begin
      check_done <= 1'b1;
      check_bad <= (check.lba == bad_lba);
      wait_n <= 2'h0;
      slow <= !slow;
    end else begin
      check_done <= 1'b0;
      check_bad <= !check_bad;
      wait_n <= (check.req && !check_done) ? wait_n + 2'h1 : 2'h0;
    end
  end
endmodule

// >>> bench/ata_security_verify_cmd_tb.sv
// Self-checking bench: Wishbone register traffic and command sequences.
// Assumes the handler acks every request and raises its interrupt on completion.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module ata_security_verify_cmd_tb;
  logic mclk, reset_n, por_n, cyc, stb, we, ack, intrq, done, bad, era, era_seen, wl, wl_seen;
  logic [7:0] adr, q;
  logic [31:0] dat, rdat;
  logic [47:0] bad_lba;
  ata_sec_pkg::check_req_t check;
  int fail_count, checks, cyc_n;
  ata_security_verify_cmd ata_security_verify_cmd_inst (.mclk(mclk), .reset_n(reset_n),
    .por_n(por_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .host_intrq(intrq),
    .check(check), .check_done(done), .check_bad(bad), .erase_start(era),
    .wear_level_start(wl));
  sector_checker_model sector_checker_model_inst (.mclk(mclk), .reset_n(reset_n),
    .check(check), .bad_lba(bad_lba), .check_done(done), .check_bad(bad));
  // ****************************************************************
  // Bus and command tasks
  // ****************************************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    dat <= {16'h0000, d};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = rdat[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] v);
    xfer(1'b0, a, 16'h0000);
    `CHK(q, v)
  endtask
  // Password commands that are refused get no sector, since no data request comes.
  task automatic cmd(input logic [7:0] op, input logic [15:0] ctl, input logic [7:0] pw,
                     input int n, input logic e);
    xfer(1'b1, 8'h1C, {8'h00, op});
    for (int i = 0; i < n; i++) xfer(1'b1, 8'h00, i == 0 ? ctl : (i <= 16 ? {pw, pw} : 16'h0000));
    while (intrq !== 1'b1) @(posedge mclk);
    xfer(1'b0, 8'h1C, 16'h0000);
    `CHK(q & 8'h89, {7'h00, e})
  endtask
  task automatic set_span(input logic [7:0] cnt);
    xfer(1'b1, 8'h0C, 16'h0000);
    xfer(1'b1, 8'h0C, 16'h0010);
    xfer(1'b1, 8'h08, 16'h0000);
    xfer(1'b1, 8'h08, {8'h00, cnt});
  endtask
  task automatic hw_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************************************
  // Clock, timeout and test sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc_n++;
    if (era === 1'b1) era_seen <= 1'b1;
    if (wl !== 1'b0) wl_seen <= 1'b1;
    if (cyc_n == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {cyc, stb, we, por_n, reset_n, era_seen, wl_seen} = 7'h00;
    adr = 8'h00;
    dat = 32'h00000000;
    bad_lba = 48'hFFFFFFFFFFFF;
    repeat (3) @(posedge mclk);
    {por_n, reset_n} <= 2'b11;
    set_span(8'h02);
    cmd(8'h42, 16'h0000, 8'h00, 0, 1'b0);
    reg_is(8'h0C, 8'h11);
    xfer(1'b1, 8'h20, 16'h0080);
    reg_is(8'h0C, 8'h00);
    xfer(1'b1, 8'h20, 16'h0000);
    bad_lba <= 48'h000000000011;
    set_span(8'h03);
    cmd(8'h42, 16'h0000, 8'h00, 0, 1'b1);
    reg_is(8'h0C, 8'h11);
    reg_is(8'h08, 8'h02);
    cmd(8'h1A, 16'h0000, 8'h00, 0, 1'b0);
    reg_is(8'h08, 8'h02);
    cmd(8'hF4, 16'h0000, 8'h00, 0, 1'b1);
    cmd(8'hF3, 16'h0000, 8'h00, 0, 1'b0);
    cmd(8'hF4, 16'h0000, 8'h5A, 256, 1'b1);
    cmd(8'hF1, 16'h0000, 8'hA5, 256, 1'b0);
    reg_is(8'h28, 8'h02);
    cmd(8'hF1, 16'h0001, 8'h3C, 256, 1'b0);
    reg_is(8'h28, 8'h02);
    hw_reset();
    reg_is(8'h28, 8'h03);
    cmd(8'hF5, 16'h0000, 8'h00, 0, 1'b0);
    reg_is(8'h08, 8'h00);
    cmd(8'hF1, 16'h0000, 8'hA5, 0, 1'b1);
    cmd(8'hF5, 16'h0000, 8'h00, 0, 1'b0);
    xfer(1'b1, 8'h20, 16'h0004);
    xfer(1'b1, 8'h20, 16'h0000);
    reg_is(8'h28, 8'h07);
    hw_reset();
    reg_is(8'h28, 8'h03);
    cmd(8'hF6, 16'h0001, 8'h3C, 256, 1'b0);
    reg_is(8'h28, 8'h00);
    cmd(8'hF1, 16'h0100, 8'hA5, 256, 1'b0);
    reg_is(8'h28, 8'h0A);
    cmd(8'hF3, 16'h0000, 8'h00, 0, 1'b0);
    cmd(8'hF4, 16'h0001, 8'h3C, 256, 1'b1);
    cmd(8'hF1, 16'h0000, 8'hA5, 256, 1'b0);
    cmd(8'hF3, 16'h0000, 8'h00, 0, 1'b0);
    cmd(8'hF4, 16'h0001, 8'h3C, 256, 1'b0);
    `CHK(era_seen, 1'b1)
    `CHK(wl_seen, 1'b0)
    results();
  end
endmodule
